// ==== ahbdma_pkg.sv ====
// Shared constants for the AHB to peripheral-bus bridge with DMA.
// Assumes a single clock domain; this file holds no logic.
package ahbdma_pkg;
  // ----------------------------------------------------------------
  // Channel layout
  // ----------------------------------------------------------------
  localparam int NUM_CH = 16;
  localparam int NAND_CH = 8;
  // ----------------------------------------------------------------
  // Descriptor layout: four words, word indices from the head address
  // ----------------------------------------------------------------
  localparam logic [1:0] DESC_NEXT = 2'h0;
  localparam logic [1:0] DESC_PADDR = 2'h1;
  localparam logic [1:0] DESC_CMD = 2'h2;
  localparam logic [1:0] DESC_DATA = 2'h3;
  localparam logic [31:0] WORD_BYTES = 32'h0000_0004;
  localparam logic [31:0] DATA_OFS = 32'h0000_000C;
  localparam int CMD_WRITE_BIT = 0;
  localparam int CMD_CHAIN_BIT = 1;
  // ----------------------------------------------------------------
  // Arbitration and decode
  // ----------------------------------------------------------------
  // After this many lockouts in a row the processor wins the next slot.
  localparam logic [1:0] LOCKOUT_LIMIT = 2'h3;
  localparam int SLOT_LO = 12;
  localparam int SLOT_BITS = 2;
  localparam logic [1:0] INTC_SLOT = 2'h0;
  localparam int HTRANS_ACTIVE_BIT = 1;
  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    A_IDLE = 3'b001,
    A_SETUP = 3'b010,
    A_ACCESS = 3'b100
  } ahbdma_apb_state_t;
  typedef enum logic [4:0] {
    D_IDLE = 5'b00001,
    D_FETCH = 5'b00010,
    D_APB = 5'b00100,
    D_WB = 5'b01000,
    D_NEXT = 5'b10000
  } ahbdma_dma_state_t;
endpackage

// ==== ahbdma_arbiter.sv ====
// Arbiter between the DMA engine and the processor path.
// Assumes requests are held until granted and take marks a free bus.
`timescale 1ns/1ps
`default_nettype none
module ahbdma_arbiter
  import ahbdma_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Requests
  input wire logic take,
  input wire logic dma_req,
  input wire logic pio_req,
  // Grants
  output logic grant_dma,
  output logic grant_pio
);
  logic [1:0] lockouts;
  logic pio_first;

  assign pio_first = (lockouts == LOCKOUT_LIMIT);
  always_comb
  begin
    grant_dma = take && dma_req && !(pio_req && pio_first);
    grant_pio = take && pio_req && !grant_dma;
  end

  // Counts only lockouts, so the processor sees at least every fourth slot.
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      lockouts <= 2'h0;
    else if (grant_pio)
      lockouts <= 2'h0;
    else if (grant_dma && pio_req)
      lockouts <= lockouts + 2'h1;
  end
endmodule // ahbdma_arbiter
`default_nettype wire

// ==== ahbdma_bridge.sv ====
// AHB slave to peripheral-bus bridge with a sixteen-channel chained DMA.
// Assumes AHB, peripheral bus and descriptor memory all run on mclk.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Peripheral bus runs on the AHB clock with no crossing.
// - Processor AHB accesses become peripheral bus reads and writes.
// - DMA and processor share one peripheral bus through an arbiter.
// - On simultaneous requests the DMA wins by default.
// - HREADY stays low until the processor bridge transfer completes.
// - Lockouts are counted; the processor is guaranteed every fourth transfer.
// - Sixteen channels share one DMA engine.
// - Each channel walks its own chain of descriptors in memory.
// - Channels 0 to 7 serve NAND channels 0 to 7; others unassigned.
// - The interrupt controller is a slave slot on the peripheral bus.
module ahbdma_bridge
  import ahbdma_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // AHB slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready_in,
  output logic [31:0] hrdata,
  output logic hready,
  output logic hresp,
  // Peripheral bus master
  output logic [31:0] paddr,
  output logic [(1<<SLOT_BITS)-1:0] psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  // Descriptor memory port
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_ack,
  // Channel control
  input wire logic start_valid,
  input wire logic [3:0] start_ch,
  input wire logic [31:0] start_addr,
  input wire logic [NAND_CH-1:0] nand_req,
  output logic [NUM_CH-1:0] chan_busy,
  output logic [NUM_CH-1:0] chan_done
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  ahbdma_apb_state_t astate;
  ahbdma_dma_state_t dstate;
  logic [31:0] ch_head [NUM_CH];
  logic [NUM_CH-1:0] ch_ready;
  logic [3:0] cur_ch;
  logic [1:0] word_idx;
  logic [31:0] d_next;
  logic [31:0] d_paddr;
  logic [31:0] d_cmd;
  logic [31:0] d_data;
  logic dma_issued;
  logic done_dma;
  logic done_pio;
  logic owner_dma;
  logic [31:0] rd_data;
  logic pio_pend;
  logic pio_dphase;
  logic pio_issued;
  logic [31:0] pio_addr;
  logic pio_write;
  logic [31:0] pio_wdata;
  logic take;
  logic dma_req;
  logic pio_req;
  logic grant_dma;
  logic grant_pio;

  // Round-robin pick starting after the last served channel.
  function automatic logic [3:0] pick(input logic [NUM_CH-1:0] rdy, input logic [3:0] last);
    logic [3:0] idx;
    logic [3:0] res;
    res = last;
    for (int i = NUM_CH; i >= 1; i--)
    begin
      idx = last + 4'(i);
      if (rdy[idx])
        res = idx;
    end
    return res;
  endfunction

  // NAND channels wait for their device; the rest run freely.
  always_comb
  begin
    for (int c = 0; c < NUM_CH; c++)
      ch_ready[c] = chan_busy[c] && ((c >= NAND_CH) || nand_req[c % NAND_CH]);
  end

  // ----------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------
  assign take = (astate == A_IDLE);
  assign dma_req = (dstate == D_APB) && !dma_issued;
  assign pio_req = pio_pend && !pio_dphase && !pio_issued;

  ahbdma_arbiter u_arb (
    .mclk(mclk),
    .arst_n(arst_n),
    .take(take),
    .dma_req(dma_req),
    .pio_req(pio_req),
    .grant_dma(grant_dma),
    .grant_pio(grant_pio)
  );

  // ----------------------------------------------------------------
  // AHB slave side
  // ----------------------------------------------------------------
  // Address is taken in the address phase, write data in the next cycle,
  // which is always a wait state so the data is stable when latched.
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      hready <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
      pio_pend <= 1'b0;
      pio_dphase <= 1'b0;
      pio_issued <= 1'b0;
      pio_addr <= 32'h0000_0000;
      pio_write <= 1'b0;
      pio_wdata <= 32'h0000_0000;
    end
    else if (!pio_pend)
    begin
      if (hsel && htrans[HTRANS_ACTIVE_BIT] && hready_in)
      begin
        pio_pend <= 1'b1;
        pio_dphase <= 1'b1;
        pio_addr <= haddr;
        pio_write <= hwrite;
        hready <= 1'b0;
      end
    end
    else
    begin
      if (pio_dphase)
      begin
        pio_dphase <= 1'b0;
        pio_wdata <= hwdata;
      end
      if (grant_pio)
        pio_issued <= 1'b1;
      if (done_pio)
      begin
        pio_pend <= 1'b0;
        pio_issued <= 1'b0;
        hrdata <= rd_data;
        hready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Peripheral bus master, clocked by mclk itself
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      astate <= A_IDLE;
      paddr <= 32'h0000_0000;
      psel <= '0;
      penable <= 1'b0;
      pwrite <= 1'b0;
      pwdata <= 32'h0000_0000;
      owner_dma <= 1'b0;
      done_dma <= 1'b0;
      done_pio <= 1'b0;
      rd_data <= 32'h0000_0000;
    end
    else
    begin
      done_dma <= 1'b0;
      done_pio <= 1'b0;
      case (astate)
        A_IDLE:
        begin
          if (grant_dma || grant_pio)
          begin
            paddr <= grant_dma ? d_paddr : pio_addr;
            pwrite <= grant_dma ? d_cmd[CMD_WRITE_BIT] : pio_write;
            pwdata <= grant_dma ? d_data : pio_wdata;
            psel <= '0;
            // The interrupt controller answers in slot INTC_SLOT like any slave.
            psel[grant_dma ? d_paddr[SLOT_LO+:SLOT_BITS] : pio_addr[SLOT_LO+:SLOT_BITS]] <= 1'b1;
            owner_dma <= grant_dma;
            astate <= A_SETUP;
          end
        end
        A_SETUP:
        begin
          penable <= 1'b1;
          astate <= A_ACCESS;
        end
        A_ACCESS:
        begin
          if (pready)
          begin
            psel <= '0;
            penable <= 1'b0;
            rd_data <= prdata;
            done_dma <= owner_dma;
            done_pio <= !owner_dma;
            astate <= A_IDLE;
          end
        end
        default:
          astate <= A_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // DMA engine: one shared engine serving all channels
  // ----------------------------------------------------------------
  // One descriptor is run per turn, so long chains cannot starve others.
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dstate <= D_IDLE;
      cur_ch <= 4'h0;
      word_idx <= 2'h0;
      d_next <= 32'h0000_0000;
      d_paddr <= 32'h0000_0000;
      d_cmd <= 32'h0000_0000;
      d_data <= 32'h0000_0000;
      dma_issued <= 1'b0;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 32'h0000_0000;
      mem_wdata <= 32'h0000_0000;
      chan_busy <= '0;
      chan_done <= '0;
      for (int c = 0; c < NUM_CH; c++)
        ch_head[c] <= 32'h0000_0000;
    end
    else
    begin
      chan_done <= '0;
      // A start for an idle channel loads its chain head; busy ones ignore it.
      if (start_valid && !chan_busy[start_ch] && !(dstate == D_NEXT && cur_ch == start_ch))
      begin
        chan_busy[start_ch] <= 1'b1;
        ch_head[start_ch] <= start_addr;
      end
      case (dstate)
        D_IDLE:
        begin
          if (|ch_ready)
          begin
            cur_ch <= pick(ch_ready, cur_ch);
            mem_addr <= ch_head[pick(ch_ready, cur_ch)];
            mem_we <= 1'b0;
            mem_req <= 1'b1;
            word_idx <= DESC_NEXT;
            dstate <= D_FETCH;
          end
        end
        D_FETCH:
        begin
          if (mem_ack)
          begin
            case (word_idx)
              DESC_NEXT: d_next <= mem_rdata;
              DESC_PADDR: d_paddr <= mem_rdata;
              DESC_CMD: d_cmd <= mem_rdata;
              default: d_data <= mem_rdata;
            endcase
            if (word_idx == DESC_DATA)
            begin
              mem_req <= 1'b0;
              dstate <= D_APB;
            end
            else
            begin
              word_idx <= word_idx + 2'h1;
              mem_addr <= mem_addr + WORD_BYTES;
            end
          end
        end
        D_APB:
        begin
          if (grant_dma)
            dma_issued <= 1'b1;
          if (done_dma)
          begin
            dma_issued <= 1'b0;
            if (d_cmd[CMD_WRITE_BIT])
              dstate <= D_NEXT;
            else
            begin
              // Read data goes back into the descriptor's data word.
              mem_addr <= ch_head[cur_ch] + DATA_OFS;
              mem_wdata <= rd_data;
              mem_we <= 1'b1;
              mem_req <= 1'b1;
              dstate <= D_WB;
            end
          end
        end
        D_WB:
        begin
          if (mem_ack)
          begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            dstate <= D_NEXT;
          end
        end
        D_NEXT:
        begin
          if (d_cmd[CMD_CHAIN_BIT])
            ch_head[cur_ch] <= d_next;
          else
          begin
            chan_busy[cur_ch] <= 1'b0;
            chan_done[cur_ch] <= 1'b1;
          end
          dstate <= D_IDLE;
        end
        default:
          dstate <= D_IDLE;
      endcase
    end
  end
endmodule // ahbdma_bridge
`default_nettype wire

// ==== ahbdma_monitor.sv ====
// Checker for the bridge, seeing only the top module's ports.
// Assumes one clock domain, mclk, with the asynchronous reset arst_n.
`timescale 1ns/1ps
`default_nettype none
module ahbdma_monitor
  import ahbdma_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // AHB slave
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hready_in,
  input wire logic hready,
  input wire logic hresp,
  // Peripheral bus
  input wire logic [31:0] paddr,
  input wire logic [(1<<SLOT_BITS)-1:0] psel,
  input wire logic penable,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  // Memory and channels
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [NUM_CH-1:0] chan_busy,
  input wire logic [NUM_CH-1:0] chan_done
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // Transfers that finish while the processor waits; one may already be in flight.
  logic [2:0] wait_xfers;
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      wait_xfers <= 3'h0;
    else if (hready)
      wait_xfers <= 3'h0;
    else if (penable && pready)
      wait_xfers <= wait_xfers + 3'h1;
  end
  sequence s_taken;
    hsel && htrans[HTRANS_ACTIVE_BIT] && hready_in && hready;
  endsequence
  sequence s_setup;
    (|psel) && !penable;
  endsequence
  property p_hready_drop;
    s_taken |=> !hready;
  endproperty
  a_hready_drop: assert property (p_hready_drop)
    else $error("hready stayed high after a request");
  property p_pio_min;
    s_taken |=> (!hready) [*4];
  endproperty
  a_pio_min: assert property (p_pio_min)
    else $error("hready returned before the bridge transfer");
  property p_apb_setup;
    s_setup |=> penable && $stable(paddr) && $stable(psel);
  endproperty
  a_apb_setup: assert property (p_apb_setup)
    else $error("setup phase not followed by access phase");
  property p_apb_hold;
    penable && !pready |=> penable && $stable(paddr) && $stable(pwdata);
  endproperty
  a_apb_hold: assert property (p_apb_hold)
    else $error("access phase changed before pready");
  property p_apb_end;
    penable && pready |=> !penable && (psel == '0);
  endproperty
  a_apb_end: assert property (p_apb_end)
    else $error("bus not released after pready");
  property p_slot;
    (|psel) |-> psel == (4'h1 << paddr[SLOT_LO +: SLOT_BITS]) && !hresp;
  endproperty
  a_slot: assert property (p_slot)
    else $error("slave select does not match address");
  property p_done_busy;
    (|chan_done) |-> (chan_done & ~$past(chan_busy)) == '0;
  endproperty
  a_done_busy: assert property (p_done_busy)
    else $error("done pulse on an idle channel");
  property p_mem_hold;
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr);
  endproperty
  a_mem_hold: assert property (p_mem_hold)
    else $error("memory request dropped before ack");
  property p_lockout;
    wait_xfers <= 3'h5;
  endproperty
  a_lockout: assert property (p_lockout)
    else $error("processor locked out too long");
endmodule // ahbdma_monitor
bind ahbdma_bridge ahbdma_monitor u_monitor (.mclk(mclk), .arst_n(arst_n), .hsel(hsel),
  .htrans(htrans), .hready_in(hready_in), .hready(hready), .hresp(hresp), .paddr(paddr),
  .psel(psel), .penable(penable), .pwdata(pwdata), .pready(pready), .mem_req(mem_req),
  .mem_addr(mem_addr), .mem_ack(mem_ack), .chan_busy(chan_busy), .chan_done(chan_done));
`default_nettype wire

// ==== ahbdma_far_model.sv ====
// Peripheral slaves and descriptor memory facing the bridge.
// Assumes the bench preloads mem and preg by hierarchical reference.
`timescale 1ns/1ps
`default_nettype none
module ahbdma_far_model
(
  // Clock, reset and pacing
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic slow,
  // Peripheral bus slaves
  input wire logic [31:0] paddr,
  input wire logic [3:0] psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  // Descriptor memory
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  output logic [31:0] mem_rdata,
  output logic mem_ack
);
  logic [31:0] preg [64];
  logic [31:0] mem [256];
  logic [1:0] pwait;
  logic [1:0] mwait;
  logic [31:0] noise;
  logic [31:0] word;
  // Outside a completed access the data lines carry a changing pattern.
  assign pready = penable && (pwait == 2'h0);
  assign prdata = (pready && !pwrite) ? preg[{paddr[13:12], paddr[5:2]}] : noise;
  assign mem_rdata = mem_ack ? word : ~noise;
  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pwait <= 2'h0;
      mwait <= 2'h0;
      mem_ack <= 1'b0;
      noise <= 32'h5A5A_0F0F;
    end
    else
    begin
      noise <= {noise[30:0], ~noise[31]};
      mem_ack <= 1'b0;
      if ((|psel) && !penable)
        pwait <= slow ? 2'h3 : 2'h0;
      else if (penable && (pwait != 2'h0))
        pwait <= pwait - 2'h1;
      if (pready && pwrite)
        preg[{paddr[13:12], paddr[5:2]}] <= pwdata;
      if (mem_req && !mem_ack && (mwait != 2'h0))
        mwait <= mwait - 2'h1;
      else if (mem_req && !mem_ack)
      begin
        mem_ack <= 1'b1;
        mwait <= slow ? 2'h2 : 2'h0;
        word <= mem[mem_addr[9:2]];
        if (mem_we)
          mem[mem_addr[9:2]] <= mem_wdata;
      end
    end
  end
endmodule // ahbdma_far_model
`default_nettype wire

// ==== tb.sv ====
// Self-checking bench: drives AHB and channel starts, watches read data and dones.
// Assumes the far model answers the peripheral bus and descriptor memory.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ahbdma_pkg::*;
  logic mclk = 1'b0;
  logic hready_in = 1'b1;
  logic arst_n, hsel, hwrite, hready, hresp, penable, pwrite, pready, slow;
  logic mem_req, mem_we, mem_ack, start_valid;
  logic [1:0] htrans;
  logic [3:0] psel, start_ch;
  logic [7:0] nand_req;
  logic [15:0] chan_busy, chan_done, done_seen;
  logic [31:0] haddr, hwdata, hrdata, paddr, pwdata, prdata, mem_addr, mem_wdata, mem_rdata;
  logic [31:0] start_addr, rdv, seed;
  logic [31:0] dd [16];
  logic [31:0] exp_q [$];
  logic hready_was = 1'b1;
  int err_count = 0;
  int total_checks = 0;
  int cycles = 0;
  always #12.5 mclk = ~mclk;
  ahbdma_bridge u_dut (.mclk(mclk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready_in(hready_in),
    .hrdata(hrdata), .hready(hready), .hresp(hresp), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack), .start_valid(start_valid),
    .start_ch(start_ch), .start_addr(start_addr), .nand_req(nand_req),
    .chan_busy(chan_busy), .chan_done(chan_done));
  ahbdma_far_model u_far (.mclk(mclk), .arst_n(arst_n), .slow(slow), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Single transfer; a read leaves its expected word for the watcher.
  task automatic ahb(input logic wr, input logic [31:0] addr, input logic [31:0] data);
    @(negedge mclk);
    while (hready !== 1'b1) @(negedge mclk);
    hsel = 1'b1;
    htrans = 2'b10;
    hwrite = wr;
    haddr = addr;
    if (!wr)
      exp_q.push_back(data);
    @(negedge mclk);
    hsel = 1'b0;
    htrans = 2'b00;
    hwdata = data;
    while (hready !== 1'b1) @(negedge mclk);
  endtask
  task automatic pio_round();
    logic [31:0] d;
    for (int s = 0; s < 4; s++)
    begin
      slow = s[0];
      d = $urandom();
      ahb(1'b1, 32'(s << SLOT_LO) | 32'h8, d);
      ahb(1'b0, 32'(s << SLOT_LO) | 32'h8, d);
      chk(u_far.preg[s * 16 + 2], d);
    end
  endtask
  // ----------------------------------------------------------------
  // Output watcher and hang guard
  // ----------------------------------------------------------------
  always @(negedge mclk)
  begin
    done_seen <= done_seen | chan_done;
    if (hready && !hready_was && exp_q.size() > 0)
      chk(hrdata, exp_q.pop_front());
    hready_was <= hready;
  end
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles > 20000)
    begin
      err_count++;
      close_out();
    end
  end
  initial
  begin
    arst_n = 1'b0;
    {hsel, hwrite, htrans, haddr, hwdata, slow} = '0;
    {start_valid, start_ch, start_addr, nand_req, done_seen} = '0;
    seed = $urandom(32'h75FB31CD);
    repeat (5) @(negedge mclk);
    arst_n = 1'b1;
    @(negedge mclk);
    chk({hready, hresp, penable, mem_req, psel, chan_busy}, 32'h0080_0000);
    // A select seen while the bus-wide ready is low must not be taken.
    hready_in = 1'b0;
    {hsel, htrans} = 3'b110;
    @(negedge mclk);
    {hsel, htrans} = 3'b000;
    hready_in = 1'b1;
    @(negedge mclk);
    chk({31'h0, hready}, 32'h0000_0001);
    chk({31'h0, penable}, 32'h0000_0000);
    $display("test reset done");
    pio_round();
    $display("test pio done");
    // Every channel gets one write descriptor; channel 15 chains to a read.
    for (int c = 0; c < NUM_CH; c++)
    begin
      dd[c] = $urandom();
      u_far.mem[c * 8] = (c == 15) ? 32'h200 : 32'h0;
      u_far.mem[c * 8 + 1] = 32'h1000 | 32'(c << 2);
      u_far.mem[c * 8 + 2] = (c == 15) ? 32'h3 : 32'h1;
      u_far.mem[c * 8 + 3] = dd[c];
    end
    rdv = $urandom();
    u_far.preg[32] = rdv;
    u_far.mem[128] = 32'h0;
    u_far.mem[129] = 32'h2000;
    u_far.mem[130] = 32'h0;
    for (int c = 0; c < NUM_CH; c++)
    begin
      @(negedge mclk);
      start_valid = 1'b1;
      start_ch = 4'(c);
      start_addr = 32'(c * 32);
    end
    @(negedge mclk);
    start_valid = 1'b0;
    pio_round();
    repeat (600) @(negedge mclk);
    chk({16'h0, chan_busy}, 32'h00FF);
    chk({16'h0, done_seen}, 32'hFF00);
    nand_req = 8'hFF;
    while (chan_busy !== 16'h0) @(negedge mclk);
    @(negedge mclk);
    chk({16'h0, done_seen}, 32'hFFFF);
    for (int c = 0; c < NUM_CH; c++)
      chk(u_far.preg[16 + c], dd[c]);
    chk(u_far.mem[131], rdv);
    $display("test dma done");
    close_out();
  end
endmodule // tb
`default_nettype wire
